// ===== design/ehbp_pkg.sv
package ehbp_pkg;
    // array geometry
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int DEPTH = 128;
    // an erased byte reads as all ones
    localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;
    // programming time, counted in edges of the programming clock
    localparam int PROG_TIME_MS = 20;
    localparam int PROG_CLK_KHZ = 50;
    localparam int PROG_TICKS = PROG_TIME_MS * PROG_CLK_KHZ;
    localparam int TICK_W = 16;
    localparam logic [TICK_W-1:0] PROG_TICKS_C = TICK_W'(PROG_TICKS);
    localparam logic [TICK_W-1:0] TICK_ZERO = 16'h0000;
    localparam logic [TICK_W-1:0] TICK_ONE = 16'h0001;
    // operating mode as decoded from the strobes
    typedef enum logic [4:0] {
        EHBP_STANDBY   = 5'b0_0001,
        EHBP_READ_SEP  = 5'b0_0010,
        EHBP_READ_MUX  = 5'b0_0100,
        EHBP_PROG_SEP  = 5'b0_1000,
        EHBP_PROG_MUX  = 5'b1_0000
    } ehbp_mode_e;
    // sequencer states
    typedef enum logic [2:0] {
        EHBP_IDLE  = 3'b001,
        EHBP_BUSY  = 3'b010,
        EHBP_WRITE = 3'b100
    } ehbp_state_e;
endpackage

// ===== design/ehbp_sync.sv
// two-stage synchroniser for pin levels
module ehbp_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;

    // the first stage feeds only the second stage
    always_comb begin
        meta_next = en_i ? d_i : meta_reg;
        q_next = en_i ? meta_reg : q_reg;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            q_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            q_reg <= q_next;
        end
    end

    assign q_o = q_reg;
endmodule

// ===== design/ehbp_top.sv
// Notes on behaviour
// (RULE1) the address pins are caught in the address latch when the latch strobe falls.
// (RULE2) with separate buses the host may tie the latch strobe to the write strobe.
// (RULE3) a low write strobe starts reprogramming and its rising edge catches the data byte.
// (RULE4) the status output is low while reprogramming and high in read mode.
// (RULE5) in a read the output gate decides whether the byte drives the data pins.
// (RULE6) the data pins drive only when chip select and output gate are both active.
// (RULE7) there are five modes: read and program, each separate or multiplexed, and standby.
// (RULE8) with chip select inactive and no programming cycle running the part is in standby, ignores controls, status high.
// (RULE9) the timing input paces programming and may come from an RC net or a clock.
// (RULE10) the array is 128 bytes of 8 bits with a 7-bit address and 8-bit data port.
// (RULE11) programming latches address and data and times itself so the host is free.
// (RULE12) all inputs but the timing input, reset and clock enable are ignored while a programming cycle runs.
// (RULE13) with tied strobes the fall latches the address and the rise latches data.
// (RULE14) separate-bus reads use the live address pins, not the latch.
// (RULE15) the status stays low for the programming time paced by the programming clock.
// (RULE16) after programming, reading that address returns the programmed byte.
module ehbp_top
    import ehbp_pkg::*;
(
    // clock, reset, enable
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    input wire logic CLK_EN_I,
    // host strobes, all active low except the latch strobe
    input wire logic CHIP_SEL_N_I,
    input wire logic OUT_GATE_N_I,
    input wire logic WRITE_N_I,
    input wire logic ADDR_LATCH_I,
    // bus mode: high when address and data share the data pins
    input wire logic MUX_BUS_I,
    // address pins
    input wire logic [ehbp_pkg::ADDR_W-1:0] BYTE_ADDRESS_PINS_I,
    // data pins as input, output and output enable
    input wire logic [ehbp_pkg::DATA_W-1:0] BYTE_IO_PINS_I,
    output logic [ehbp_pkg::DATA_W-1:0] BYTE_IO_PINS_O,
    output logic BYTE_IO_PINS_OE_O,
    // programming timing input
    input wire logic PROG_TIMING_I,
    // status
    output logic READY_NOT_BUSY_O,
    output ehbp_pkg::ehbp_mode_e MODE_O
);
    import ehbp_pkg::*;

    localparam int SW = 5 + ADDR_W + DATA_W + 1;

    logic [SW-1:0] raw;
    logic [SW-1:0] syn;
    logic cs_act;
    logic oe_act;
    logic we_act;
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic ale;
    logic mux;
    logic tmg;
    logic [ADDR_W-1:0] a_pins;
    logic [DATA_W-1:0] d_pins;

    // every pin but clock, reset and enable is off-domain, so those pass two flops first; the active-low strobes
    // cross inverted so that the synchroniser's all-zero reset reads as idle and no
    // false strobe edge appears right after reset
    assign raw = {~CHIP_SEL_N_I, ~OUT_GATE_N_I, ~WRITE_N_I, ADDR_LATCH_I, MUX_BUS_I,
                  BYTE_ADDRESS_PINS_I, BYTE_IO_PINS_I, PROG_TIMING_I};

    ehbp_sync #(.W(SW)) u_sync (
        .clk_i(CLOCK_I),
        .rst_i(RESET_I),
        .en_i(CLK_EN_I),
        .d_i(raw),
        .q_o(syn)
    );

    assign {cs_act, oe_act, we_act, ale, mux, a_pins, d_pins, tmg} = syn;
    // back to pin polarity for the sequencer
    assign cs_n = ~cs_act;
    assign oe_n = ~oe_act;
    assign we_n = ~we_act;

    // array storage
    logic [DATA_W-1:0] mem [DEPTH]; // RULE10

    ehbp_state_e state_reg;
    ehbp_state_e state_next;
    logic [ADDR_W-1:0] alat_reg;
    logic [ADDR_W-1:0] alat_next;
    logic [DATA_W-1:0] dlat_reg;
    logic [DATA_W-1:0] dlat_next;
    logic [TICK_W-1:0] tick_reg;
    logic [TICK_W-1:0] tick_next;
    logic ale_d_reg;
    logic we_d_reg;
    logic tmg_d_reg;
    logic [DATA_W-1:0] dout_reg;
    logic [DATA_W-1:0] dout_next;
    logic oe_reg;
    logic oe_next;
    logic rdy_reg;
    logic rdy_next;
    ehbp_mode_e mode_reg;
    ehbp_mode_e mode_next;
    logic ale_fall;
    logic we_fall;
    logic we_rise;
    logic tmg_rise;
    logic [ADDR_W-1:0] rd_addr;

    // edges are taken on synchronised levels, never on first stages
    assign ale_fall = ale_d_reg & ~ale;
    assign we_fall = we_d_reg & ~we_n;
    assign we_rise = ~we_d_reg & we_n;
    assign tmg_rise = ~tmg_d_reg & tmg; // RULE9

    // separate reads use the live pins, multiplexed reads the latch
    // a separate-bus read follows the pins, so the host must hold the address
    assign rd_addr = mux ? alat_reg : a_pins; // RULE14

    // next-state for the sequencer, latches and outputs
    always_comb begin
        state_next = state_reg;
        alat_next = alat_reg;
        dlat_next = dlat_reg;
        tick_next = tick_reg;
        dout_next = dout_reg;
        oe_next = 1'b0;
        rdy_next = 1'b1;
        mode_next = EHBP_STANDBY;
        unique case (state_reg)
            EHBP_IDLE: begin
                if (!cs_n) begin // RULE8
                    // latch strobe falls, or the write strobe falls on a separate bus
                    if (ale_fall || (!mux && we_fall)) begin
                        alat_next = mux ? d_pins[ADDR_W-1:0] : a_pins; // RULE1 RULE13
                    end
                    if (we_rise && oe_n) begin
                        dlat_next = d_pins; // RULE3 RULE13
                        tick_next = PROG_TICKS_C;
                        state_next = EHBP_BUSY; // RULE11
                        rdy_next = 1'b0; // RULE4
                    end
                    if (!we_n || we_rise) begin
                        mode_next = mux ? EHBP_PROG_MUX : EHBP_PROG_SEP; // RULE7
                    end else begin
                        mode_next = mux ? EHBP_READ_MUX : EHBP_READ_SEP; // RULE7
                    end
                    // output drive needs both select and gate
                    if (!oe_n && we_n && !we_rise) begin // RULE5 RULE6
                        oe_next = 1'b1;
                        dout_next = mem[rd_addr];
                    end
                end
            end
            EHBP_BUSY: begin
                // pins other than the timing input are not looked at until the timer ends
                rdy_next = 1'b0; // RULE4 RULE12 RULE15
                // mode is held from the start cycle, the bus-mode pin is not read
                mode_next = mode_reg; // RULE12
                // one count per rising edge of the timing input
                if (tmg_rise) begin
                    tick_next = tick_reg - TICK_ONE;
                    if (tick_reg == TICK_ONE) begin
                        state_next = EHBP_WRITE;
                    end
                end
            end
            EHBP_WRITE: begin
                // commit the byte, then return to idle
                rdy_next = 1'b1;
                state_next = EHBP_IDLE;
                tick_next = TICK_ZERO;
            end
            default: begin
                state_next = EHBP_IDLE;
            end
        endcase
    end

    // state registers; the enable freezes everything
    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            state_reg <= EHBP_IDLE;
            alat_reg <= '0;
            dlat_reg <= '0;
            tick_reg <= TICK_ZERO;
            ale_d_reg <= 1'b0;
            we_d_reg <= 1'b1;
            tmg_d_reg <= 1'b0;
            dout_reg <= '0;
            oe_reg <= 1'b0;
            rdy_reg <= 1'b1;
            mode_reg <= EHBP_STANDBY;
        end else if (CLK_EN_I) begin
            // edge detectors keep tracking while busy so no stale edge fires later
            state_reg <= state_next;
            alat_reg <= alat_next;
            dlat_reg <= dlat_next;
            tick_reg <= tick_next;
            ale_d_reg <= ale;
            we_d_reg <= we_n;
            tmg_d_reg <= tmg;
            dout_reg <= dout_next;
            oe_reg <= oe_next;
            rdy_reg <= rdy_next;
            mode_reg <= mode_next;
        end
    end

    // array write; no reset so it can map to memory
    always_ff @(posedge CLOCK_I) begin
        if (CLK_EN_I && state_reg == EHBP_WRITE) begin
            mem[alat_reg] <= dlat_reg; // RULE16
        end
    end

    assign BYTE_IO_PINS_O = dout_reg;
    assign BYTE_IO_PINS_OE_O = oe_reg; // RULE6
    assign READY_NOT_BUSY_O = rdy_reg;
    assign MODE_O = mode_reg;
endmodule

// ===== test/ehbp_top_asserts.sv
module ehbp_top_chk
    import ehbp_pkg::*;
(
    // watched pins
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    input wire logic CHIP_SEL_N_I,
    input wire logic OUT_GATE_N_I,
    input wire logic WRITE_N_I,
    input wire logic BYTE_IO_PINS_OE_O,
    input wire logic READY_NOT_BUSY_O,
    input wire ehbp_pkg::ehbp_mode_e MODE_O
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RESET_I);
    // pins pass a synchroniser, so lags are 3 cycles or ranges
    AST_OE_SEL: assert property ($rose(BYTE_IO_PINS_OE_O) |->
        !$past(CHIP_SEL_N_I, 3) && !$past(OUT_GATE_N_I, 3)) else $error("drive unselected");
    AST_DESEL: assert property (CHIP_SEL_N_I [*5] |-> !BYTE_IO_PINS_OE_O)
        else $error("drive in standby");
    AST_BUSY_OFF: assert property (!READY_NOT_BUSY_O |-> !BYTE_IO_PINS_OE_O)
        else $error("drive while busy");
    AST_BUSY_PROG: assert property (!READY_NOT_BUSY_O |->
        MODE_O inside {EHBP_PROG_SEP, EHBP_PROG_MUX}) else $error("busy outside program");
    AST_READ_RDY: assert property (MODE_O inside {EHBP_READ_SEP, EHBP_READ_MUX} |->
        READY_NOT_BUSY_O) else $error("read mode not ready");
    AST_ONEHOT: assert property ($onehot(MODE_O)) else $error("mode not one-hot");
    AST_OE_READ: assert property (BYTE_IO_PINS_OE_O |->
        MODE_O inside {EHBP_READ_SEP, EHBP_READ_MUX}) else $error("drive outside read");
    AST_BUSY_MIN: assert property ($fell(READY_NOT_BUSY_O) |->
        !READY_NOT_BUSY_O [*8]) else $error("busy too short");
    AST_BUSY_GO: assert property ($rose(WRITE_N_I) && !CHIP_SEL_N_I && OUT_GATE_N_I &&
        READY_NOT_BUSY_O |-> ##[3:5] !READY_NOT_BUSY_O) else $error("no program start");
    // main scenarios reached
    CV_PROG: cover property ($fell(READY_NOT_BUSY_O));
    CV_MUX_RD: cover property (BYTE_IO_PINS_OE_O && MODE_O == EHBP_READ_MUX);
    CV_DONE: cover property ($rose(READY_NOT_BUSY_O));
endmodule

// ===== test/ehbp_host_model.sv
module ehbp_host_model
    import ehbp_pkg::*;
(
    // clock and device drive
    input wire logic clk_i,
    input wire logic [ehbp_pkg::DATA_W-1:0] dev_d_i,
    input wire logic dev_oe_i,
    // host pins
    output logic cs_n_o,
    output logic oe_n_o,
    output logic we_n_o,
    output logic ale_o,
    output logic mux_o,
    output logic [ehbp_pkg::ADDR_W-1:0] addr_o,
    output logic [ehbp_pkg::DATA_W-1:0] bus_o,
    output logic tim_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] drv = 8'h00;
    logic [7:0] junk = 8'h5A;
    logic drv_en = 1'b0;
    logic [1:0] tc = 2'h0;
    // idle: deselected, separate bus, strobes high
    initial {cs_n_o, oe_n_o, we_n_o, ale_o, mux_o, addr_o, tim_o} = {5'h1E, 7'h00, 1'b0};
    // free timing clock, 3 cycles a level so every level is seen
    always @(posedge clk_i) begin
        tc <= (tc == 2'h2) ? 2'h0 : tc + 2'h1;
        tim_o <= tim_o ^ (tc == 2'h2);
        junk <= ~junk;
    end
    // a floating bus flips each cycle so stale data never matches
    assign bus_o = dev_oe_i ? dev_d_i : (drv_en ? drv : junk);
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // program one byte; bus freed once the byte is latched
    task automatic prog(input logic mux, input logic [6:0] a, input logic [7:0] d);
        {mux_o, addr_o, drv, drv_en, cs_n_o, ale_o} = {mux, a, mux ? {1'b0, a} : d, 3'h5};
        step(4);
        {ale_o, we_n_o} = {1'b0, mux};
        step(4);
        {drv, we_n_o} = {d, 1'b0};
        step(4);
        {ale_o, we_n_o} = {!mux, 1'b1};
        step(4);
        {drv_en, cs_n_o} = 2'h1;
    endtask
    // one read; address stays on the bus until the latch strobe has fallen
    task automatic rd(input logic mux, input logic [6:0] a, input logic cs_n, input logic oe_n);
        {mux_o, addr_o, drv, drv_en, cs_n_o, ale_o} = {mux, a, 1'b0, a, mux, cs_n, 1'b1};
        step(4);
        ale_o = !mux;
        step(4);
        {drv_en, oe_n_o} = {1'b0, oe_n};
        step(6);
    endtask
    task automatic idle;
        {oe_n_o, cs_n_o} = 2'h3;
        step(4);
    endtask
endmodule

// ===== test/eeprom_host_bus_port_tb.sv
module eeprom_host_bus_port_tb
    import ehbp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cs_n, oe_n, we_n, ale, mux, tim, oe, rdy;
    logic [6:0] addr;
    logic [7:0] bus, dout;
    ehbp_mode_e mode;
    int miscompares = 0;
    int comparisons = 0;
    // 200 MHz clock
    always #2.5 clk = ~clk;
    ehbp_top ehbp_top_inst (.CLOCK_I(clk), .RESET_I(rst), .CLK_EN_I(1'b1), .CHIP_SEL_N_I(cs_n),
        .OUT_GATE_N_I(oe_n), .WRITE_N_I(we_n), .ADDR_LATCH_I(ale), .MUX_BUS_I(mux),
        .BYTE_ADDRESS_PINS_I(addr), .BYTE_IO_PINS_I(bus), .BYTE_IO_PINS_O(dout),
        .BYTE_IO_PINS_OE_O(oe), .PROG_TIMING_I(tim), .READY_NOT_BUSY_O(rdy), .MODE_O(mode));
    ehbp_host_model ehbp_host_model_inst (.clk_i(clk), .dev_d_i(dout), .dev_oe_i(oe),
        .cs_n_o(cs_n), .oe_n_o(oe_n), .we_n_o(we_n), .ale_o(ale), .mux_o(mux), .addr_o(addr),
        .bus_o(bus), .tim_o(tim));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // bounded wait for a status level; lo catches a cycle that ends too soon
    task automatic wait_rdy(input logic v, input int lo, input int hi);
        int n;
        n = 0;
        while (rdy !== v && n < hi) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk({7'h00, rdy}, {7'h00, v});
        chk({7'h00, n >= lo}, 8'h01);
    endtask
    task automatic t_standby;
        ehbp_host_model_inst.rd(1'b0, 7'h7F, 1'b1, 1'b0);
        chk({7'h00, oe}, 8'h00);
        chk({7'h00, rdy}, 8'h01);
        chk({3'h0, mode}, {3'h0, EHBP_STANDBY});
        ehbp_host_model_inst.rd(1'b0, 7'h7F, 1'b0, 1'b1);
        chk({7'h00, oe}, 8'h00);
        ehbp_host_model_inst.idle;
        $display("test standby done");
    endtask
    // top address, tied strobes, a read tried while busy
    task automatic t_prog_sep;
        ehbp_host_model_inst.prog(1'b0, 7'h7F, 8'hA5);
        wait_rdy(1'b0, 0, 8);
        ehbp_host_model_inst.rd(1'b0, 7'h7F, 1'b0, 1'b0);
        chk({7'h00, oe}, 8'h00);
        ehbp_host_model_inst.idle;
        wait_rdy(1'b1, 5000, 8000);
        ehbp_host_model_inst.rd(1'b0, 7'h7F, 1'b0, 1'b0);
        chk({7'h00, oe}, 8'h01);
        chk(dout, 8'hA5);
        ehbp_host_model_inst.idle;
        $display("test prog_sep done");
    endtask
    // bottom address on the shared bus, then a live-address read
    task automatic t_prog_mux;
        ehbp_host_model_inst.prog(1'b1, 7'h00, 8'h3C);
        wait_rdy(1'b0, 0, 8);
        wait_rdy(1'b1, 5000, 8000);
        ehbp_host_model_inst.rd(1'b1, 7'h00, 1'b0, 1'b0);
        chk(dout, 8'h3C);
        ehbp_host_model_inst.idle;
        ehbp_host_model_inst.rd(1'b0, 7'h7F, 1'b0, 1'b0);
        chk(dout, 8'hA5);
        ehbp_host_model_inst.idle;
        $display("test prog_mux done");
    endtask
    task report_and_stop;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        t_standby;
        t_prog_sep;
        t_prog_mux;
        report_and_stop;
    end
    // watchdog: two programs of about 6000 cycles plus reads
    initial begin
        #150000;
        miscompares++;
        report_and_stop;
    end
endmodule
bind ehbp_top ehbp_top_chk ehbp_top_chk_inst (.CLOCK_I(CLOCK_I), .RESET_I(RESET_I),
    .CHIP_SEL_N_I(CHIP_SEL_N_I), .OUT_GATE_N_I(OUT_GATE_N_I), .WRITE_N_I(WRITE_N_I),
    .BYTE_IO_PINS_OE_O(BYTE_IO_PINS_OE_O), .READY_NOT_BUSY_O(READY_NOT_BUSY_O), .MODE_O(MODE_O));
